// >>> hdl/eeprom_pkg.sv
// constants, types and states of the two-wire eeprom engine
// assumes one system clock that oversamples the serial lines
package eeprom_pkg;

  // ----------------------------------------------------------------
  // array geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int PAGE_W = 5;
  localparam int PAGE_BYTES = 32;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;

  // ----------------------------------------------------------------
  // framing
  // ----------------------------------------------------------------
  localparam logic [3:0] DEV_TYPE = 4'hA;
  localparam int DEV_TYPE_POS = 4;
  localparam int HW_ADDR_POS = 1;
  localparam int RW_POS = 0;
  localparam int ADDR_HI_W = 4;
  localparam logic [3:0] BIT_LAST = 4'h8;
  localparam logic [3:0] BIT_ACK = 4'h9;
  localparam logic [3:0] BIT_MSB = 4'h7;

  // ----------------------------------------------------------------
  // timing and buffering
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int FIFO_DEPTH = 8;

  typedef struct packed {
    logic scl;
    logic sda;
  } line_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_DEV = 3'h1,
    ST_AHI = 3'h3,
    ST_ALO = 3'h2,
    ST_WDATA = 3'h6,
    ST_PROG = 3'h7,
    ST_RDATA = 3'h5
  } state_type;

endpackage

// >>> hdl/serial_eeprom_rw_engine.sv
// two-wire eeprom engine: addressing, page writes, reads, programming
// assumes an external open-drain wire resolved from sda_oe_o
//
// Contract
// - write is start, device byte with direction low, address, data
// - 12-bit word address selects a byte; address and data acked
// - after write stop, self-timed programming; inputs ignored meanwhile
// - one programming cycle stores 1 to 32 bytes of one page
// - further data bytes may follow; each acked; programming at stop
// - only low five address bits advance, wrapping inside the page
// - write device byte unacked while programming, acked afterwards
// - protect input high protects whole array; low means none
// - protect input sampled at write stop; later changes harmless
// - protected write still acked, no programming, ready at once
// - reads start like writes with direction bit high
// - address counter holds last address plus one, kept across frames
// - read address wraps from last byte to first byte
// - read device byte acked, then byte at counter shifted out
// - master nack on ninth clock ends the read, back to standby
// - each master ack makes the next byte follow, wrapping at end
// - unwritten locations read as all ones
// - respond only to type code and matching hardware address
// - mismatching device byte is not acked; back to standby
// - first address byte low nibble bits 11..8, second bits 7..0
`timescale 1ns/10ps
`default_nettype none

module read_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic flush_i,
  // fill side
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  // drain side
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] store [DEPTH];
  logic [PW:0] wr_reg;
  logic [PW:0] rd_reg;
  logic push;
  logic pop;

  assign in_ready_o = (wr_reg - rd_reg) != (PW+1)'(DEPTH);
  assign out_valid_o = wr_reg != rd_reg;
  assign out_data_o = store[rd_reg[PW-1:0]];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  always_ff @(posedge clk_i) begin
    if (push) begin
      store[wr_reg[PW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else if (flush_i) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= rd_reg + 1'b1;
      end
    end
  end
endmodule // read_fifo

module serial_eeprom_rw_engine #(
  parameter int unsigned PROG_TIME_NS = 1000000
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // serial lines
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // straps and status
  input wire logic [2:0] hw_addr_i,
  input wire logic wp_i,
  output logic busy_o
);
  import eeprom_pkg::*;

  localparam int unsigned PROG_CYCLES = PROG_TIME_NS / CLK_PERIOD_NS;
  localparam int MEM_BYTES = 1 << ADDR_W;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [5:0] meta_reg;
  logic [5:0] sync_reg;
  line_type line_now;
  line_type line_prev_reg;
  logic wp_now;
  logic [2:0] hw_now;
  logic scl_rise, scl_fall, start_det, stop_det;
  state_type state_reg, state_next;
  logic [3:0] bit_reg;
  logic [7:0] shift_reg;
  logic [7:0] tx_reg;
  logic nack_reg;
  logic [ADDR_HI_W-1:0] ahi_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [ADDR_W-1:0] pf_addr_reg;
  logic [7:0] page_buf [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] mask_reg;
  logic [31:0] prog_reg;
  logic [7:0] mem [MEM_BYTES];
  logic [MEM_BYTES-1:0] written_reg;
  logic byte_end, ack_now, load_now;
  logic fifo_push_ready, fifo_out_valid;
  logic [7:0] fifo_out_data, pf_data;
  logic sda_oe_reg, busy_reg;

  function automatic logic dev_match(input logic [7:0] b,
                                     input logic [2:0] hw);
    dev_match = b[7:DEV_TYPE_POS] == DEV_TYPE &&
                b[DEV_TYPE_POS-1:HW_ADDR_POS] == hw;
  endfunction

  // ----------------------------------------------------------------
  // line sampling and bus events
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_reg <= 6'h3C;
      sync_reg <= 6'h3C;
      line_prev_reg <= 2'h3;
    end else begin
      meta_reg <= {scl_i, sda_i, wp_i, hw_addr_i};
      sync_reg <= meta_reg;
      line_prev_reg <= line_now;
    end
  end

  assign line_now = sync_reg[5:4];
  assign wp_now = sync_reg[3];
  assign hw_now = sync_reg[2:0];
  // both lines pass equal stages, so their relative order is kept
  assign scl_rise = line_now.scl & ~line_prev_reg.scl;
  assign scl_fall = ~line_now.scl & line_prev_reg.scl;
  assign start_det = line_now.scl & line_prev_reg.scl &
                     line_prev_reg.sda & ~line_now.sda;
  assign stop_det = line_now.scl & line_prev_reg.scl &
                    ~line_prev_reg.sda & line_now.sda;

  assign byte_end = scl_fall && bit_reg == BIT_LAST;
  assign ack_now = byte_end && (state_reg == ST_AHI ||
                   state_reg == ST_ALO || state_reg == ST_WDATA ||
                   (state_reg == ST_DEV && dev_match(shift_reg, hw_now)));
  assign load_now = scl_fall && bit_reg == BIT_ACK &&
                    state_reg == ST_RDATA && !nack_reg;

  // ----------------------------------------------------------------
  // frame sequencing
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_PROG: begin
        if (prog_reg == PROG_CYCLES - 1) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        if (start_det) begin
          state_next = ST_DEV;
        end else if (stop_det) begin
          if (state_reg == ST_WDATA && |mask_reg && !wp_now) begin
            state_next = ST_PROG;
          end else begin
            state_next = ST_IDLE;
          end
        end else if (byte_end) begin
          case (state_reg)
            ST_DEV: begin
              if (!dev_match(shift_reg, hw_now)) begin
                state_next = ST_IDLE;
              end else if (shift_reg[RW_POS]) begin
                state_next = ST_RDATA;
              end else begin
                state_next = ST_AHI;
              end
            end
            ST_AHI: state_next = ST_ALO;
            ST_ALO: state_next = ST_WDATA;
            default: state_next = state_reg;
          endcase
        end else if (scl_fall && bit_reg == BIT_ACK &&
                     state_reg == ST_RDATA && nack_reg) begin
          state_next = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
      busy_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      busy_reg <= state_next == ST_PROG;
    end
  end

  // ----------------------------------------------------------------
  // bit counting and shifting
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      bit_reg <= 4'h0;
    end else if (start_det || state_reg == ST_IDLE ||
                 state_reg == ST_PROG) begin
      bit_reg <= 4'h0;
    end else if (scl_rise && bit_reg != BIT_ACK) begin
      bit_reg <= bit_reg + 4'h1;
    end else if (scl_fall && bit_reg == BIT_ACK) begin
      bit_reg <= 4'h0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      shift_reg <= 8'h00;
      nack_reg <= 1'b0;
    end else if (scl_rise) begin
      if (bit_reg < BIT_LAST) begin
        shift_reg <= {shift_reg[6:0], line_now.sda};
      end else if (bit_reg == BIT_LAST) begin
        nack_reg <= line_now.sda;
      end
    end
  end

  // ----------------------------------------------------------------
  // address counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ahi_reg <= '0;
      addr_reg <= '0;
    end else if (byte_end && state_reg == ST_AHI) begin
      ahi_reg <= shift_reg[ADDR_HI_W-1:0];
    end else if (byte_end && state_reg == ST_ALO) begin
      addr_reg <= {ahi_reg, shift_reg};
    end else if (byte_end && state_reg == ST_WDATA) begin
      addr_reg[PAGE_W-1:0] <= addr_reg[PAGE_W-1:0] + 1'b1;
    end else if (load_now) begin
      addr_reg <= addr_reg + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // page buffer and programming
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (byte_end && state_reg == ST_WDATA) begin
      page_buf[addr_reg[PAGE_W-1:0]] <= shift_reg;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mask_reg <= '0;
    end else if (start_det && state_reg != ST_PROG) begin
      mask_reg <= '0;
    end else if (state_reg == ST_PROG && state_next == ST_IDLE) begin
      mask_reg <= '0;
    end else if (byte_end && state_reg == ST_WDATA) begin
      mask_reg[addr_reg[PAGE_W-1:0]] <= 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prog_reg <= '0;
    end else if (state_reg == ST_PROG) begin
      prog_reg <= prog_reg + 32'h1;
    end else begin
      prog_reg <= '0;
    end
  end

  // one page byte committed per cycle over the first 32 timer counts
  always_ff @(posedge clk_i) begin
    if (state_reg == ST_PROG && prog_reg < PAGE_BYTES &&
        mask_reg[prog_reg[PAGE_W-1:0]]) begin
      mem[{addr_reg[ADDR_W-1:PAGE_W], prog_reg[PAGE_W-1:0]}] <=
        page_buf[prog_reg[PAGE_W-1:0]];
    end
  end

  // a written map stands in for an erased array, avoiding array reset
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      written_reg <= '0;
    end else if (state_reg == ST_PROG && prog_reg < PAGE_BYTES &&
                 mask_reg[prog_reg[PAGE_W-1:0]]) begin
      written_reg[{addr_reg[ADDR_W-1:PAGE_W],
                   prog_reg[PAGE_W-1:0]}] <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // read prefetch
  // ----------------------------------------------------------------
  assign pf_data = written_reg[pf_addr_reg] ? mem[pf_addr_reg]
                                             : ERASED_BYTE;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pf_addr_reg <= '0;
    end else if (state_reg != ST_RDATA) begin
      pf_addr_reg <= addr_reg;
    end else if (fifo_push_ready) begin
      pf_addr_reg <= pf_addr_reg + 1'b1;
    end
  end

  read_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .flush_i(state_reg != ST_RDATA),
    .in_valid_i(state_reg == ST_RDATA),
    .in_data_i(pf_data),
    .in_ready_o(fifo_push_ready),
    .out_valid_o(fifo_out_valid),
    .out_data_o(fifo_out_data),
    .out_ready_i(load_now)
  );

  // ----------------------------------------------------------------
  // data line drive
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_reg <= 8'h00;
    end else if (load_now) begin
      // an empty fifo cannot occur: half a bit period fills it
      tx_reg <= fifo_out_valid ? fifo_out_data : ERASED_BYTE;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sda_oe_reg <= 1'b0;
    end else if (state_reg == ST_PROG || start_det || stop_det) begin
      sda_oe_reg <= 1'b0;
    end else if (scl_fall) begin
      if (ack_now) begin
        sda_oe_reg <= 1'b1;
      end else if (load_now) begin
        sda_oe_reg <= fifo_out_valid ? ~fifo_out_data[7] : 1'b0;
      end else if (state_reg == ST_RDATA && bit_reg != 4'h0 &&
                   bit_reg < BIT_LAST) begin
        sda_oe_reg <= ~tx_reg[3'(BIT_MSB - bit_reg)];
      end else begin
        sda_oe_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sda_o <= 1'b0;
    end else begin
      sda_o <= 1'b0;
    end
  end

  assign sda_oe_o = sda_oe_reg;
  assign busy_o = busy_reg;

endmodule // serial_eeprom_rw_engine

`default_nettype wire

// >>> bench/eeprom_engine_chk.sv
// checker for the eeprom engine, bound onto its ports
// assumes clk_i at 200 MHz and a shortened programming time
`timescale 1ns/10ps
`default_nettype none
module eeprom_engine_chk #(
  parameter int unsigned PROG_TIME_NS = 1000
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // serial lines
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  // straps and status
  input wire logic [2:0] hw_addr_i,
  input wire logic wp_i,
  input wire logic busy_o
);
  localparam int PROG_CYC = PROG_TIME_NS / eeprom_pkg::CLK_PERIOD_NS;
  int busy_cnt;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // one cycle of slack either way, the exact edge is the designer's
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i) busy_cnt <= 0;
    else busy_cnt <= busy_o ? busy_cnt + 1 : 0;
  // programming only starts once the master has let both lines go
  sequence s_bus_free;
    scl_i && sda_i;
  endsequence
  a_open_drain: assert property (sda_o == 1'h0)
    else $error("data line driven high");
  a_busy_silent: assert property (busy_o |-> !sda_oe_o)
    else $error("answered while programming");
  a_prog_at_stop: assert property ($rose(busy_o) |-> s_bus_free)
    else $error("programming began inside a frame");
  a_prog_min: assert property ($rose(busy_o) |=> busy_o [*8])
    else $error("programming cut short");
  a_prog_length: assert property ($fell(busy_o) |->
    (busy_cnt + 1 - PROG_CYC) inside {[0:2]})
    else $error("programming time off");
  a_wp_no_prog: assert property ($rose(busy_o) |-> !$past(wp_i, 3))
    else $error("protected write started programming");
  a_oe_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("data line moved while clock high");
  a_oe_hold: assert property (scl_i & sda_oe_o |=> sda_oe_o | !scl_i)
    else $error("pull released while clock high");
endmodule  // eeprom_engine_chk
bind serial_eeprom_rw_engine eeprom_engine_chk #(
  .PROG_TIME_NS(PROG_TIME_NS)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
  .hw_addr_i(hw_addr_i), .wp_i(wp_i), .busy_o(busy_o));
`default_nettype wire

// >>> bench/bus_master_model.sv
// bus master model: drives the serial clock and pulls the data line
// assumes an open-drain wire with pull-up resolved by the bench
`timescale 1ns/10ps
`default_nettype none
module bus_master_model (
  // clock
  input wire logic clk_i,
  // serial lines
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_oe_o
);
  initial begin
    scl_o = 1'h1;
    sda_oe_o = 1'h0;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // data moves two clocks after the clock falls, never with it
  task automatic cond(input logic stp);
    wt(2);
    sda_oe_o = stp;
    wt(6);
    scl_o = 1'h1;
    wt(8);
    sda_oe_o = ~stp;
    wt(8);
    scl_o = stp;
  endtask
  // 16 clocks a bit, sampled mid-high
  task automatic bit_xfer(input logic b, output logic r);
    wt(2);
    sda_oe_o = ~b;
    wt(6);
    scl_o = 1'h1;
    wt(4);
    r = sda_i;
    wt(4);
    scl_o = 1'h0;
  endtask
  task automatic byte_xfer(input logic [7:0] d, input logic ack_i,
      output logic [7:0] q, output logic ack_o);
    for (int i = 7; i >= 0; i--) bit_xfer(d[i], q[i]);
    bit_xfer(ack_i, ack_o);
  endtask
endmodule  // bus_master_model
`default_nettype wire

// >>> bench/serial_eeprom_rw_engine_tb.sv
// testbench for the eeprom engine driven by the bus master model
// assumes eeprom_pkg, the engine and bench/bus_master_model
`timescale 1ns/10ps
`default_nettype none
module serial_eeprom_rw_engine_tb;
  import eeprom_pkg::*;
  localparam logic [2:0] HW = 3'h5;
  logic clk_i, rst_i, wp_i, scl, m_oe, d_oe, busy, sda, sdo;
  logic [2:0] hw_addr_i;
  int errors = 0, tests_run = 0, cycles = 0;
  assign sda = ~(d_oe | m_oe);  // pull-up
  serial_eeprom_rw_engine #(.PROG_TIME_NS(1000)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda), .sda_o(sdo),
    .sda_oe_o(d_oe), .hw_addr_i(hw_addr_i), .wp_i(wp_i), .busy_o(busy));
  bus_master_model u_master (
    .clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_oe_o(m_oe));
  initial begin
    clk_i = 1'h0;
    forever #2.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin  // whole run is near 8000 clocks
    cycles++;
    if (cycles == 40000) errors++;
    if (cycles == 40000) stop_test();
  end
  task automatic stop_test();
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    tests_run++;
    if (got !== exp) errors++;
    if (got !== exp) $display("wrong value at %0t: %h %h", $time, got, exp);
  endtask
  // ea is the level seen in the ninth bit: 0 acked, 1 not
  task automatic tx(input logic [7:0] d, input logic ai,
      input logic [7:0] eq, input logic ea);
    logic [7:0] q;
    logic a;
    u_master.byte_xfer(d, ai, q, a);
    chk({3'h0, q, a}, {3'h0, eq, ea});
  endtask
  task automatic dev(input logic rd, input logic ea);
    u_master.cond(1'h0);
    tx({DEV_TYPE, HW, rd}, 1'h1, {DEV_TYPE, HW, rd}, ea);
  endtask
  task automatic seek(input logic [11:0] a);
    dev(1'h0, 1'h0);
    tx({4'hC, a[11:8]}, 1'h1, {4'hC, a[11:8]}, 1'h0);
    tx(a[7:0], 1'h1, a[7:0], 1'h0);
  endtask
  task automatic wait_ready();
    for (int n = 0; n < 400 && busy !== 1'h0; n++) @(negedge clk_i);
    chk({11'h0, busy}, 12'h0);
  endtask
  task automatic t_address();
    hw_addr_i = 3'h3;
    dev(1'h1, 1'h1);
    hw_addr_i = 3'h4;
    dev(1'h1, 1'h1);
    hw_addr_i = HW;
    u_master.cond(1'h0);
    tx({4'hB, HW, 1'h1}, 1'h1, {4'hB, HW, 1'h1}, 1'h1);
    dev(1'h1, 1'h0);
    chk({11'h0, sdo}, 12'h0);
    tx(8'hFF, 1'h0, ERASED_BYTE, 1'h0);
    tx(8'hFF, 1'h1, ERASED_BYTE, 1'h1);
  endtask
  task automatic t_page();
    seek(12'h3FE);
    tx(8'h11, 1'h1, 8'h11, 1'h0);
    tx(8'h22, 1'h1, 8'h22, 1'h0);
    tx(8'h33, 1'h1, 8'h33, 1'h0);
    u_master.cond(1'h1);
    chk({11'h0, busy}, 12'h1);
    dev(1'h0, 1'h1);
    wait_ready();
    seek(12'h3FE);
    dev(1'h1, 1'h0);
    tx(8'hFF, 1'h1, 8'h11, 1'h1);
    dev(1'h1, 1'h0);
    tx(8'hFF, 1'h1, 8'h22, 1'h1);
    seek(12'h3E0);
    dev(1'h1, 1'h0);
    tx(8'hFF, 1'h1, 8'h33, 1'h1);
  endtask
  task automatic t_protect();
    wp_i = 1'h1;
    seek(12'h000);
    tx(8'h55, 1'h1, 8'h55, 1'h0);
    u_master.cond(1'h1);
    chk({11'h0, busy}, 12'h0);
    seek(12'h000);
    dev(1'h1, 1'h0);
    tx(8'hFF, 1'h1, ERASED_BYTE, 1'h1);
    wp_i = 1'h0;
    seek(12'h000);
    tx(8'h66, 1'h1, 8'h66, 1'h0);
    u_master.cond(1'h1);
    wp_i = 1'h1;
    chk({11'h0, busy}, 12'h1);
    wait_ready();
    wp_i = 1'h0;
  endtask
  task automatic t_wrap();
    seek(12'hFFF);
    tx(8'hA5, 1'h1, 8'hA5, 1'h0);
    u_master.cond(1'h1);
    wait_ready();
    seek(12'hFFF);
    dev(1'h1, 1'h0);
    tx(8'hFF, 1'h0, 8'hA5, 1'h0);
    tx(8'hFF, 1'h1, 8'h66, 1'h1);
  endtask
  initial begin
    rst_i = 1'h1;
    wp_i = 1'h0;
    hw_addr_i = HW;
    repeat (20) @(negedge clk_i);
    rst_i = 1'h0;
    repeat (8) @(negedge clk_i);
    t_address();
    t_page();
    t_protect();
    t_wrap();
    stop_test();
  end
endmodule  // serial_eeprom_rw_engine_tb
`default_nettype wire
